// ### pkg/icc_pkg.sv
/*
  Shared constants and types of the input capture channel: register map,
  control field layout, mode encodings and the register bus carrier.
  Assumes a plain register port with one-cycle strobes and 16-bit data.
*/
package icc_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned PTR_W = 2;
  localparam int unsigned CNT_W = 3;

  // register offsets (word index on the plain port)
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_BUFFER = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h3;

  // control register fields
  localparam int unsigned BIT_STOP_IN_IDLE = 13;
  localparam int unsigned BIT_TIMER_SELECT = 7;
  localparam int unsigned BIT_CPI_HI = 6;
  localparam int unsigned BIT_CPI_LO = 5;
  localparam int unsigned BIT_OVERFLOW = 4;
  localparam int unsigned BIT_NOT_EMPTY = 3;
  localparam int unsigned BIT_MODE_HI = 2;
  localparam int unsigned BIT_MODE_LO = 0;

  // interrupt status / mask bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_CAPTURE = 0;
  localparam int unsigned IRQ_OVERFLOW = 1;
  localparam int unsigned IRQ_WAKE = 2;

  localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [PTR_W-1:0] PTR_ONE = 2'h1;
  localparam logic [3:0] PRE_ZERO = 4'h0;
  localparam logic [3:0] PRE_ONE = 4'h1;
  localparam logic [3:0] PRE_LAST_4 = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hf;

  typedef enum logic [2:0] {
    ICC_MODE_OFF = 3'h0,
    ICC_MODE_EVERY_EDGE = 3'h1,
    ICC_MODE_FALLING = 3'h2,
    ICC_MODE_RISING = 3'h3,
    ICC_MODE_RISE_4 = 3'h4,
    ICC_MODE_RISE_16 = 3'h5,
    ICC_MODE_UNUSED = 3'h6,
    ICC_MODE_WAKE_ONLY = 3'h7
  } icc_mode_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } icc_bus_req_s;

endpackage

// ### rtl/icc_fifo.sv
/*
  Four-word capture buffer: oldest value on the output, push ignored when full.
  Assumes the owner never pushes while full, it flags overflow instead.
*/
`timescale 1ns/10ps
module icc_fifo (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [icc_pkg::DATA_W-1:0] push_data,
  input wire logic pop,
  output logic [icc_pkg::DATA_W-1:0] head_data,
  output logic [icc_pkg::CNT_W-1:0] level
);
  logic [icc_pkg::DATA_W-1:0] mem_reg [icc_pkg::FIFO_DEPTH];
  logic [icc_pkg::PTR_W-1:0] wptr_reg;
  logic [icc_pkg::PTR_W-1:0] rptr_reg;
  logic [icc_pkg::CNT_W-1:0] level_reg;
  wire full = (level_reg == icc_pkg::CNT_W'(icc_pkg::FIFO_DEPTH));
  wire empty = (level_reg == icc_pkg::CNT_ZERO);
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem_reg[wptr_reg] <= push_data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      level_reg <= icc_pkg::CNT_ZERO;
    end else if (flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      level_reg <= icc_pkg::CNT_ZERO;
    end else begin
      if (do_push) begin
        wptr_reg <= wptr_reg + icc_pkg::PTR_ONE;
      end
      if (do_pop) begin
        rptr_reg <= rptr_reg + icc_pkg::PTR_ONE;
      end
      if (do_push && !do_pop) begin
        level_reg <= level_reg + icc_pkg::CNT_ONE;
      end else if (do_pop && !do_push) begin
        level_reg <= level_reg - icc_pkg::CNT_ONE;
      end
    end
  end

  assign head_data = empty ? icc_pkg::RESET_WORD : mem_reg[rptr_reg];
  assign level = level_reg;
endmodule

// ### rtl/icc_channel.sv
/*
  Input capture channel: edge detection, prescale, timer select, four-word
  buffer, captures-per-interrupt counter, sticky interrupt status and mask.
  Assumes capture pin, timer counts and idle/sleep levels are synchronous
  to sys_clk; registers reached over a plain strobe port, read data a cycle later.
*/
// Summary of operation
// - each qualifying event that finds room in the buffer latches the full 16-bit count of the selected timer.
// - timer select 1 captures timer b, 0 captures timer c.
// - interrupt every first, second, third or fourth capture per field value.
// - read-only overflow flag set by hardware on capture overflow.
// - read-only not-empty flag shows unread values in the buffer.
// - captured values wait in a four-word first-in first-out buffer.
// - mode 000 turns capture off.
// - mode 001 captures both edges, interrupt on every capture.
// - mode 010 captures falling edges, 011 rising edges.
// - mode 100 captures every fourth rising edge, 101 every sixteenth.
// - mode 110 behaves as disabled.
// - mode 111 gives rising-edge interrupt only in sleep or idle.
// - stop-in-idle set halts capture while the processor idles; mode 111 wake still works.
// - a capture pin event can wake the device from sleep and idle.
// - control bits 15-14 and 12-8 read as zero.
`timescale 1ns/10ps
module icc_channel (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire icc_pkg::icc_bus_req_s bus_req,
  output logic [icc_pkg::DATA_W-1:0] bus_rdata,
  input wire logic capture_input_pin,
  input wire logic [icc_pkg::DATA_W-1:0] timer_b_count,
  input wire logic [icc_pkg::DATA_W-1:0] timer_c_count,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic capture_irq,
  output logic wake_request
);
  // control state
  logic capture_stop_in_idle_reg;
  logic capture_timer_select_reg;
  logic [1:0] captures_per_interrupt_reg;
  icc_pkg::icc_mode_e capture_mode_field_reg;
  logic capture_overflow_flag_reg;
  logic pin_prev_reg;
  logic [3:0] prescale_reg;
  logic [3:0] prescale_next;
  logic [icc_pkg::CNT_W-1:0] cpi_count_reg;
  logic [icc_pkg::CNT_W-1:0] cpi_count_next;
  logic [icc_pkg::IRQ_W-1:0] irq_status_reg;
  logic [icc_pkg::IRQ_W-1:0] irq_status_next;
  logic [icc_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [icc_pkg::DATA_W-1:0] rdata_reg;
  logic [icc_pkg::DATA_W-1:0] rdata_next;
  logic irq_reg;
  logic wake_reg;
  logic [icc_pkg::DATA_W-1:0] fifo_head;
  logic [icc_pkg::CNT_W-1:0] fifo_level;

  function automatic logic is_capture_mode(input icc_pkg::icc_mode_e m);
    is_capture_mode = (m == icc_pkg::ICC_MODE_EVERY_EDGE) || (m == icc_pkg::ICC_MODE_FALLING) ||
                      (m == icc_pkg::ICC_MODE_RISING) || (m == icc_pkg::ICC_MODE_RISE_4) ||
                      (m == icc_pkg::ICC_MODE_RISE_16);
  endfunction

  // register decode
  wire hit_control = (bus_req.addr == icc_pkg::OFS_CONTROL);
  wire hit_buffer = (bus_req.addr == icc_pkg::OFS_BUFFER);
  wire hit_status = (bus_req.addr == icc_pkg::OFS_IRQ_STATUS);
  wire hit_mask = (bus_req.addr == icc_pkg::OFS_IRQ_MASK);
  wire wr_control = bus_req.wr && hit_control;
  wire wr_status = bus_req.wr && hit_status;
  wire wr_mask = bus_req.wr && hit_mask;
  wire rd_buffer = bus_req.rd && hit_buffer;
  wire rd_control = bus_req.rd && hit_control;
  wire rd_status = bus_req.rd && hit_status;
  wire rd_mask = bus_req.rd && hit_mask;
  wire icc_pkg::icc_mode_e mode_written =
    icc_pkg::icc_mode_e'(bus_req.wdata[icc_pkg::BIT_MODE_HI:icc_pkg::BIT_MODE_LO]);
  wire mode_change = wr_control && (mode_written != capture_mode_field_reg);
  wire mode_off_written = wr_control && !is_capture_mode(mode_written);
  wire counters_clear = mode_change || mode_off_written;

  // halted while idle when asked to stop; sleep also stops the capture clock
  wire halted = (capture_stop_in_idle_reg && cpu_idle) || cpu_sleep;
  wire capture_active = is_capture_mode(capture_mode_field_reg) && !halted;

  wire rise = capture_input_pin && !pin_prev_reg;
  wire fall = !capture_input_pin && pin_prev_reg;

  // edge qualification per mode
  wire rise_4_hit = rise && (prescale_reg == icc_pkg::PRE_LAST_4);
  wire rise_16_hit = rise && (prescale_reg == icc_pkg::PRE_LAST_16);
  logic edge_event;
  always_comb begin
    case (capture_mode_field_reg)
      icc_pkg::ICC_MODE_EVERY_EDGE: edge_event = rise || fall;
      icc_pkg::ICC_MODE_FALLING: edge_event = fall;
      icc_pkg::ICC_MODE_RISING: edge_event = rise;
      icc_pkg::ICC_MODE_RISE_4: edge_event = rise_4_hit;
      icc_pkg::ICC_MODE_RISE_16: edge_event = rise_16_hit;
      default: edge_event = 1'b0;
    endcase
  end
  wire capture_event = capture_active && edge_event;

  wire fifo_full = (fifo_level == icc_pkg::CNT_W'(icc_pkg::FIFO_DEPTH));
  wire do_capture = capture_event && !fifo_full;
  wire overflow_event = capture_event && fifo_full;
  // timer count is taken on the same edge that qualifies the pin event
  wire [icc_pkg::DATA_W-1:0] selected_count =
    capture_timer_select_reg ? timer_b_count : timer_c_count;

  // prescaler counts rising edges only in the prescaled modes
  wire prescale_mode = (capture_mode_field_reg == icc_pkg::ICC_MODE_RISE_4) ||
                       (capture_mode_field_reg == icc_pkg::ICC_MODE_RISE_16);
  always_comb begin
    prescale_next = prescale_reg;
    if (counters_clear) begin
      prescale_next = icc_pkg::PRE_ZERO;
    end else if (capture_active && prescale_mode && rise) begin
      if (rise_4_hit && (capture_mode_field_reg == icc_pkg::ICC_MODE_RISE_4)) begin
        prescale_next = icc_pkg::PRE_ZERO;
      end else begin
        prescale_next = prescale_reg + icc_pkg::PRE_ONE;
      end
    end
  end

  // captures-per-interrupt; every-edge mode interrupts on each capture
  wire [icc_pkg::CNT_W-1:0] cpi_target = {1'b0, captures_per_interrupt_reg} + icc_pkg::CNT_ONE;
  wire cpi_bypass = (capture_mode_field_reg == icc_pkg::ICC_MODE_EVERY_EDGE);
  // greater-or-equal so a smaller field written mid-run still fires at once
  wire cpi_reached = (cpi_count_reg + icc_pkg::CNT_ONE) >= cpi_target;
  wire capture_int_event = do_capture && (cpi_bypass || cpi_reached);
  always_comb begin
    cpi_count_next = cpi_count_reg;
    if (counters_clear) begin
      cpi_count_next = icc_pkg::CNT_ZERO;
    end else if (do_capture) begin
      cpi_count_next = capture_int_event ? icc_pkg::CNT_ZERO : cpi_count_reg + icc_pkg::CNT_ONE;
    end
  end

  // interrupt-only pin while asleep or idle
  // stop-in-idle and the other controls are ignored in the interrupt-only mode
  wire wake_only = (capture_mode_field_reg == icc_pkg::ICC_MODE_WAKE_ONLY);
  wire wake_event = wake_only && (cpu_sleep || cpu_idle) && rise;
  // a capture edge during idle with the module running also wakes the core
  wire idle_capture_wake = cpu_idle && capture_event;
  wire wake_set = wake_event || idle_capture_wake;

  wire [icc_pkg::IRQ_W-1:0] irq_set = {wake_set, overflow_event, capture_int_event};
  wire [icc_pkg::IRQ_W-1:0] irq_clr = wr_status ? bus_req.wdata[icc_pkg::IRQ_W-1:0] : icc_pkg::IRQ_RESET;
  // set wins over a write-one-to-clear in the same cycle
  assign irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
  // the line follows a mask write on the same edge as the status, no stale cycle
  wire [icc_pkg::IRQ_W-1:0] irq_mask_next = wr_mask ? bus_req.wdata[icc_pkg::IRQ_W-1:0] : irq_mask_reg;

  // overflow clears once the buffer is drained or the module is switched off
  wire ovf_clear = (rd_buffer && (fifo_level == icc_pkg::CNT_ONE)) || mode_off_written;

  // control read image, unimplemented bits zero
  logic [icc_pkg::DATA_W-1:0] control_image;
  always_comb begin
    control_image = icc_pkg::RESET_WORD;
    control_image[icc_pkg::BIT_STOP_IN_IDLE] = capture_stop_in_idle_reg;
    control_image[icc_pkg::BIT_TIMER_SELECT] = capture_timer_select_reg;
    control_image[icc_pkg::BIT_CPI_HI:icc_pkg::BIT_CPI_LO] = captures_per_interrupt_reg;
    control_image[icc_pkg::BIT_OVERFLOW] = capture_overflow_flag_reg;
    control_image[icc_pkg::BIT_NOT_EMPTY] = (fifo_level != icc_pkg::CNT_ZERO);
    control_image[icc_pkg::BIT_MODE_HI:icc_pkg::BIT_MODE_LO] = capture_mode_field_reg;
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = icc_pkg::RESET_WORD;
    // pop and data share one strobe, so a read never loses a word
    if (rd_control) begin
      rdata_next = control_image;
    end else if (rd_buffer) begin
      rdata_next = fifo_head;
    end else if (rd_status) begin
      rdata_next = {{(icc_pkg::DATA_W-icc_pkg::IRQ_W){1'b0}}, irq_status_reg};
    end else if (rd_mask) begin
      rdata_next = {{(icc_pkg::DATA_W-icc_pkg::IRQ_W){1'b0}}, irq_mask_reg};
    end
  end

  // flush on the off write also drops a capture landing in the same cycle
  icc_fifo u_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .flush(mode_off_written),
    .push(do_capture),
    .push_data(selected_count),
    .pop(rd_buffer),
    .head_data(fifo_head),
    .level(fifo_level)
  );

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_stop_in_idle_reg <= 1'b0;
      capture_timer_select_reg <= 1'b0;
      captures_per_interrupt_reg <= 2'h0;
      capture_mode_field_reg <= icc_pkg::ICC_MODE_OFF;
    end else if (wr_control) begin
      // overflow and not-empty are read-only; writes to them are dropped
      capture_stop_in_idle_reg <= bus_req.wdata[icc_pkg::BIT_STOP_IN_IDLE];
      capture_timer_select_reg <= bus_req.wdata[icc_pkg::BIT_TIMER_SELECT];
      captures_per_interrupt_reg <= bus_req.wdata[icc_pkg::BIT_CPI_HI:icc_pkg::BIT_CPI_LO];
      capture_mode_field_reg <= mode_written;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_overflow_flag_reg <= 1'b0;
    // a dropped capture wins over the drain or off-write clear in the same cycle
    end else if (overflow_event) begin
      capture_overflow_flag_reg <= 1'b1;
    end else if (ovf_clear) begin
      capture_overflow_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      // a pin already high at release counts as a rising edge on the first edge
      pin_prev_reg <= 1'b0;
      prescale_reg <= icc_pkg::PRE_ZERO;
      cpi_count_reg <= icc_pkg::CNT_ZERO;
    end else begin
      pin_prev_reg <= capture_input_pin;
      prescale_reg <= prescale_next;
      cpi_count_reg <= cpi_count_next;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_reg <= icc_pkg::IRQ_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_reg <= icc_pkg::IRQ_RESET;
    end else begin
      irq_mask_reg <= irq_mask_next;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= icc_pkg::RESET_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // both outputs come from flops and move on the same edge as the status
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_next & irq_mask_next);
      wake_reg <= wake_set;
    end
  end

  assign bus_rdata = rdata_reg;
  assign capture_irq = irq_reg;
  assign wake_request = wake_reg;
endmodule

// ### bench/icc_pin_source.sv
/*
  Model of the signal source on the capture pin: toggles the pin a set
  number of times with a set idle gap between changes.
  Assumes start is a one-cycle pulse given while busy is low.
*/
`timescale 1ns/10ps
module icc_pin_source (
  input wire logic sys_clk,
  input wire logic start,
  input wire logic [5:0] toggles,
  input wire logic [3:0] gap,
  output logic pin,
  output logic busy
);
  logic [5:0] left_reg = 6'h00;
  logic [3:0] wait_reg = 4'h0;
  initial pin = 1'b0;
  assign busy = left_reg != 6'h00;
  // gap 0 gives a change every cycle, the hardest case for edge detection
  always @(posedge sys_clk) begin
    if (start) begin
      left_reg <= toggles;
      wait_reg <= gap;
    end else if (busy && wait_reg == 4'h0) begin
      pin <= !pin;
      left_reg <= left_reg - 6'h01;
      wait_reg <= gap;
    end else if (busy) begin
      wait_reg <= wait_reg - 4'h1;
    end
  end
endmodule

// ### bench/icc_monitor.sv
/*
  Port checker of the capture channel, with shadows of control and mask.
  Assumes it is bound to icc_channel, one clock domain.
*/
`timescale 1ns/10ps
module icc_monitor (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire icc_pkg::icc_bus_req_s bus_req,
  input wire logic [15:0] bus_rdata,
  input wire logic capture_input_pin,
  input wire logic [15:0] timer_b_count,
  input wire logic [15:0] timer_c_count,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic capture_irq,
  input wire logic wake_request
);
  logic [15:0] ctl_reg;
  logic [2:0] msk_reg;
  wire logic [2:0] md = ctl_reg[2:0];
  wire logic [15:0] ctl_rw = ctl_reg & 16'h20e7;
  wire logic run = !cpu_sleep && !(cpu_idle && ctl_reg[13]);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_reg <= 16'h0000;
      msk_reg <= 3'h0;
    end else if (bus_req.wr && bus_req.addr == 4'h0) begin
      ctl_reg <= bus_req.wdata;
    end else if (bus_req.wr && bus_req.addr == 4'h3) begin
      msk_reg <= bus_req.wdata[2:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(logic [3:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  // a capture or an overflow must follow; both are unmasked here
  sequence s_edge;
    run && !bus_req.wr && msk_reg[1:0] == 2'h3 && (md == 3'h1 && $changed(capture_input_pin)
      || ctl_reg[6:5] == 2'h0 && (md == 3'h3 && $rose(capture_input_pin) || md == 3'h2 && $fell(capture_input_pin)));
  endsequence
  chk_ctl_zero_bits: assert property (s_rd(4'h0) |=> bus_rdata[15:14] == 2'h0 && bus_rdata[12:8] == 5'h00)
    else $error("control unimplemented bits not zero");
  chk_ctl_read_back: assert property (s_rd(4'h0) |=> (bus_rdata & 16'h20e7) == $past(ctl_rw))
    else $error("control read back differs");
  chk_off_empty: assert property (s_rd(4'h0) ##0 (md == 3'h0 || md == 3'h6) && $past(md, 2) == md |=> bus_rdata[4:3] == 2'h0)
    else $error("buffer flags set while disabled");
  chk_rdata_quiet: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data outside read cycle");
  chk_wake_cause: assert property (wake_request |-> $past(cpu_idle) || $past(cpu_sleep))
    else $error("wake without idle or sleep");
  chk_wake_rise: assert property (md == 3'h7 && cpu_sleep && !bus_req.wr && $rose(capture_input_pin) |=> wake_request)
    else $error("no wake on rising edge in sleep");
  chk_edge_irq: assert property (s_edge |=> capture_irq)
    else $error("no interrupt after qualifying edge");
  chk_irq_status: assert property (s_rd(4'h2) |=> (|(bus_rdata[2:0] & msk_reg)) == $past(capture_irq))
    else $error("interrupt line disagrees with status");
endmodule

// ### bench/icc_channel_tb_top.sv
/*
  Bench of the capture channel: bus tasks, random pin traffic and a model.
  Assumes icc_monitor and icc_pin_source compiled before this file.
*/
`timescale 1ns/10ps
module icc_channel_tb_top;
  logic sys_clk = 0, reset_n = 0, cpu_idle = 0, cpu_sleep = 0, go = 0;
  logic [5:0] tog = 0;
  logic [3:0] gap = 0;
  logic [15:0] tb_cnt = 0, tc_cnt = 0, rdata, ctl_m = 0, exp_rd = 0;
  logic [2:0] msk_m = 0, st_m = 0, cpi_m = 0, md;
  logic [3:0] pre_m = 0;
  logic pin, prev_m = 0, ovf_m = 0, busy, chk_rd = 0, irq, wake, rise, fall, ev, wk_m = 0, pop_m, ovc_m;
  logic [15:0] q[$];
  icc_pkg::icc_bus_req_s req = '0;
  int seed = 40, error_cnt = 0, checks_done = 0;
  icc_channel icc_channel_inst (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(req), .bus_rdata(rdata),
    .capture_input_pin(pin), .timer_b_count(tb_cnt), .timer_c_count(tc_cnt), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .capture_irq(irq), .wake_request(wake));
  icc_pin_source icc_pin_source_inst (.sys_clk(sys_clk), .start(go), .toggles(tog), .gap(gap), .pin(pin),
    .busy(busy));
  always #2 sys_clk = !sys_clk;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic [3:0] a, input logic [15:0] d, input logic w);
    @(posedge sys_clk);
    req <= '{a, d, w, !w};
    @(posedge sys_clk);
    req <= '0;
  endtask
  task automatic pulse(input logic [5:0] n, input logic [3:0] g);
    @(posedge sys_clk);
    tog <= n;
    gap <= g;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    for (int i = 0; i < 2000 && (busy || go); i++) @(posedge sys_clk);
  endtask
  // reference model: sees inputs as the design samples them at each edge
  always @(posedge sys_clk) begin
    tb_cnt <= tb_cnt + 16'h0001;
    tc_cnt <= tc_cnt + 16'h0101;
    if (reset_n) begin
      if (chk_rd) cmp(rdata, exp_rd);
      cmp({15'h0000, irq}, {15'h0000, |(st_m & msk_m)});
      cmp({15'h0000, wake}, {15'h0000, wk_m});
      chk_rd = req.rd;
      pop_m = req.rd && req.addr == 4'h1 && q.size() != 0;
      ovc_m = pop_m && q.size() == 1;
      md = ctl_m[2:0];
      case (req.addr)
        4'h0: exp_rd = ctl_m | {11'h000, ovf_m, q.size() != 0, 3'h0};
        4'h1: exp_rd = q.size() != 0 ? q[0] : 16'h0000;
        4'h2: exp_rd = {13'h0000, st_m};
        4'h3: exp_rd = {13'h0000, msk_m};
        default: exp_rd = 16'h0000;
      endcase
      rise = pin && !prev_m;
      fall = !pin && prev_m;
      prev_m = pin;
      ev = 1'b0;
      if (!cpu_sleep && !(cpu_idle && ctl_m[13])) begin
        ev = md == 3'h1 && (rise || fall) || md == 3'h2 && fall || md == 3'h3 && rise;
        if ((md == 3'h4 || md == 3'h5) && rise) begin
          ev = pre_m == (md == 3'h4 ? 4'h3 : 4'hf);
          pre_m = ev ? 4'h0 : pre_m + 4'h1;
        end
      end
      wk_m = md == 3'h7 && (cpu_sleep || cpu_idle) && rise || cpu_idle && ev;
      if (req.wr && req.addr == 4'h2) st_m = st_m & ~req.wdata[2:0];
      if (wk_m) st_m[2] = 1'b1;
      if (ev && q.size() == 4) begin
        ovf_m = 1'b1;
        st_m[1] = 1'b1;
      end else if (ev) begin
        q.push_back(ctl_m[7] ? tb_cnt : tc_cnt);
        if (md == 3'h1 || cpi_m == {1'b0, ctl_m[6:5]}) begin
          st_m[0] = 1'b1;
          cpi_m = 3'h0;
        end else cpi_m = cpi_m + 3'h1;
      end
      if (pop_m) void'(q.pop_front());
      if (ovc_m) ovf_m = 1'b0;
      if (req.wr && req.addr == 4'h3) msk_m = req.wdata[2:0];
      if (req.wr && req.addr == 4'h0) begin
        if (req.wdata[2:0] != md || req.wdata[2:0] == 3'h0) begin
          pre_m = 4'h0;
          cpi_m = 3'h0;
        end
        if (req.wdata[2:0] == 3'h0 || req.wdata[2:0] >= 3'h6) begin
          q.delete();
          ovf_m = 1'b0;
        end
        ctl_m = req.wdata & 16'h20e7;
      end
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    bus(4'h9, 16'hffff, 1'b1);
    for (int a = 0; a < 5; a++) bus(a == 4 ? 4'h9 : 4'(a), 16'h0000, 1'b0);
    bus(4'h0, 16'hffff, 1'b1);
    bus(4'h0, 16'h0000, 1'b0);
    bus(4'h3, 16'h0007, 1'b1);
    for (int m = 0; m < 24; m++) begin
      bus(4'h0, 16'($random(seed)) & 16'h00e0 | 16'(m & 7), 1'b1);
      fork
        pulse(6'($random(seed) & 7), 4'($random(seed) & 3));
        repeat (12) bus(4'h1, 16'h0000, 1'b0);
      join
      for (int a = 0; a < 4; a++) bus(4'(a), 16'h0000, 1'b0);
      bus(4'h2, 16'h0007, 1'b1);
    end
    for (int c = 0; c < 4; c++) begin
      bus(4'h0, 16'h0000, 1'b1);
      bus(4'h0, {9'h000, 2'(c), 5'h03}, 1'b1);
      pulse(6'(2 * c + 2), 4'h0);
      repeat (4) bus(4'h1, 16'h0000, 1'b0);
      bus(4'h2, 16'h0007, 1'b1);
    end
    bus(4'h0, 16'h0003, 1'b1);
    pulse(6'd12, 4'h0);
    bus(4'h0, 16'h0000, 1'b0);
    repeat (5) bus(4'h1, 16'h0000, 1'b0);
    cpu_idle <= 1'b1;
    bus(4'h0, 16'h2003, 1'b1);
    pulse(6'd4, 4'h0);
    bus(4'h0, 16'h0003, 1'b1);
    pulse(6'd4, 4'h1);
    cpu_idle <= 1'b0;
    cpu_sleep <= 1'b1;
    bus(4'h0, 16'h0007, 1'b1);
    pulse(6'd4, 4'h2);
    cpu_sleep <= 1'b0;
    bus(4'h2, 16'h0007, 1'b1);
    finish_test;
  end
  initial begin
    #200000;
    error_cnt++;
    finish_test;
  end
endmodule
bind icc_channel icc_monitor icc_monitor_inst (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .capture_input_pin(capture_input_pin), .timer_b_count(timer_b_count),
  .timer_c_count(timer_c_count), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .capture_irq(capture_irq),
  .wake_request(wake_request));
